//--- src/pin_steer_pkg.sv
package pin_steer_pkg;

    // ======================================================
    // sizes
    localparam int NUM_PORTS = 5;
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;
    localparam int PORT_SEL_WIDTH = 3;

    // ======================================================
    // port indices
    localparam logic [PORT_SEL_WIDTH-1:0] PORT_A = 3'h0;
    localparam logic [PORT_SEL_WIDTH-1:0] PORT_B = 3'h1;
    localparam logic [PORT_SEL_WIDTH-1:0] PORT_C = 3'h2;
    localparam logic [PORT_SEL_WIDTH-1:0] PORT_D = 3'h3;
    localparam logic [PORT_SEL_WIDTH-1:0] PORT_E = 3'h4;

    // ======================================================
    // register map (byte addresses)
    localparam logic [ADDR_WIDTH-1:0] PORT_STRIDE = 8'h10;
    localparam logic [1:0] SUB_DIRECTION = 2'h0;
    localparam logic [1:0] SUB_PIN_LEVEL = 2'h1;
    localparam logic [1:0] SUB_OUT_LATCH = 2'h2;
    localparam logic [1:0] SUB_ANALOG_SEL = 2'h3;
    localparam logic [ADDR_WIDTH-1:0] STEERING_ADDR = 8'h50;
    localparam int SUB_LSB = 2;
    localparam int PORT_LSB = 4;

    // ======================================================
    // reset values
    localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 8'hFF;
    localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 8'h00;
    localparam logic [PORT_WIDTH-1:0] ANALOG_RESET = 8'hFF;
    localparam logic [7:0] STEERING_RESET = 8'h00;
    localparam logic [7:0] STEERING_MASK = 8'h7F;
    localparam logic [NUM_PORTS-1:0] ANALOG_PORTS = 5'h13;

    // ======================================================
    // steering bit positions
    localparam int SEL_CAPCMP2 = 0;
    localparam int SEL_SLAVE_SELECT = 1;
    localparam int SEL_COMPARATOR2 = 2;
    localparam int SEL_LATCH_INV = 3;
    localparam int SEL_PWM_B = 4;
    localparam int SEL_TIMER_GATE = 5;
    localparam int SEL_CAPCMP3 = 6;

    // ======================================================
    // candidate pins: {port, bit} for select 0 and select 1
    localparam logic [2:0] BIT0 = 3'h0;
    localparam logic [2:0] BIT1 = 3'h1;
    localparam logic [2:0] BIT3 = 3'h3;
    localparam logic [2:0] BIT4 = 3'h4;
    localparam logic [2:0] BIT5 = 3'h5;
    localparam logic [2:0] BIT6 = 3'h6;

    // ======================================================
    // per-port override bundle
    typedef struct packed {
        logic [PORT_WIDTH-1:0] en;
        logic [PORT_WIDTH-1:0] val;
    } pin_ovr_t;

    typedef struct packed {
        logic [PORT_SEL_WIDTH-1:0] port;
        logic [2:0] bit_idx;
    } pin_loc_t;

endpackage

//--- src/port_slice.sv
`timescale 1ns/100ps

module port_slice
    import pin_steer_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH,
    parameter bit HAS_ANALOG = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register writes
    input wire logic wr_direction_i,
    input wire logic wr_latch_i,
    input wire logic wr_analog_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // overrides and pins
    input wire pin_ovr_t ovr_i,
    input wire logic [WIDTH-1:0] pin_i,
    // state
    output logic [WIDTH-1:0] direction_o,
    output logic [WIDTH-1:0] latch_o,
    output logic [WIDTH-1:0] analog_o,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o
);

    // ======================================================
    // registers
    logic [WIDTH-1:0] direction_ff, nxt_direction;
    logic [WIDTH-1:0] latch_ff, nxt_latch;
    logic [WIDTH-1:0] analog_ff, nxt_analog;
    logic [WIDTH-1:0] sync1_ff, sync2_ff;
    logic [WIDTH-1:0] pin_ff, nxt_pin;
    logic [WIDTH-1:0] oe_ff, nxt_oe;

    always_comb begin
        nxt_direction = wr_direction_i ? wdata_i : direction_ff;
        nxt_latch = wr_latch_i ? wdata_i : latch_ff;
        nxt_analog = analog_ff;
        if (HAS_ANALOG && wr_analog_i) begin
            nxt_analog = wdata_i;
        end
    end

    // ======================================================
    // pad drive, one bit each
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            // peripheral takes the pad regardless of direction
            if (ovr_i.en[i]) begin
                nxt_pin[i] = ovr_i.val[i];
                nxt_oe[i] = 1'b1;
            end else begin
                nxt_pin[i] = latch_ff[i];
                nxt_oe[i] = ~direction_ff[i];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            direction_ff <= DIRECTION_RESET;
            latch_ff <= LATCH_RESET;
            analog_ff <= HAS_ANALOG ? ANALOG_RESET : '0;
            sync1_ff <= '0;
            sync2_ff <= '0;
            pin_ff <= '0;
            oe_ff <= '0;
        end else begin
            direction_ff <= nxt_direction;
            latch_ff <= nxt_latch;
            analog_ff <= nxt_analog;
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
        end
    end

    // analog pins read zero; output side untouched
    assign level_o = sync2_ff & ~analog_ff;
    assign direction_o = direction_ff;
    assign latch_o = latch_ff;
    assign analog_o = analog_ff;
    assign pin_o = pin_ff;
    assign pin_oe_o = oe_ff;

endmodule

//--- src/port_pin_steering.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// - five ports, each with direction, pin-level and output latch registers
// - an enabled peripheral takes control of its pin from the port
// - writing pin-level register stores into the output latch, same as latch write
// - latch register reads return latch contents, not pin levels
// - pin-level register reads return the sensed pin levels
// - analog-select bit disables that pin's digital input
// - steering register moves seven peripheral signals between two pins each
// - steering writes never alter direction registers
// - a steered function's overrides go to its currently selected pin
// - the unselected pin keeps plain port behaviour
// - timer gate from port B bit 5 when 0, port C bit 4 when 1
// - direction 1 is input with driver off, 0 drives the latch value
// - analog pins read 0 digitally, digital output still works
module port_pin_steering
    import pin_steer_pkg::*;
#(
    parameter int PORTS = NUM_PORTS,
    parameter int WIDTH = PORT_WIDTH,
    parameter logic [NUM_PORTS-1:0] ANALOG_MAP = ANALOG_PORTS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [ADDR_WIDTH-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [WIDTH-1:0] rdata_o,
    // device pins
    input wire logic [PORTS-1:0][WIDTH-1:0] pin_i,
    output logic [PORTS-1:0][WIDTH-1:0] pin_o,
    output logic [PORTS-1:0][WIDTH-1:0] pin_oe_o,
    // peripheral outputs and their enables
    input wire logic pwm_b_output_i,
    input wire logic pwm_b_en_i,
    input wire logic capcmp2_out_i,
    input wire logic capcmp2_en_i,
    input wire logic capcmp3_out_i,
    input wire logic capcmp3_en_i,
    input wire logic latch_inverted_output_i,
    input wire logic latch_inv_en_i,
    input wire logic comparator2_out_i,
    input wire logic comparator2_en_i,
    // peripheral inputs
    output logic slave_select_o,
    output logic timer_gate_input_o,
    // steering state
    output logic [7:0] pin_function_steering_o
);

    // ======================================================
    // candidate pins
    localparam pin_loc_t SS_LOC0 = '{port: PORT_A, bit_idx: BIT5};
    localparam pin_loc_t SS_LOC1 = '{port: PORT_A, bit_idx: BIT0};
    localparam pin_loc_t C2_LOC0 = '{port: PORT_A, bit_idx: BIT5};
    localparam pin_loc_t C2_LOC1 = '{port: PORT_A, bit_idx: BIT0};
    localparam pin_loc_t LI_LOC0 = '{port: PORT_A, bit_idx: BIT5};
    localparam pin_loc_t LI_LOC1 = '{port: PORT_A, bit_idx: BIT0};
    localparam pin_loc_t PB_LOC0 = '{port: PORT_C, bit_idx: BIT0};
    localparam pin_loc_t PB_LOC1 = '{port: PORT_B, bit_idx: BIT5};
    localparam pin_loc_t CC2_LOC0 = '{port: PORT_C, bit_idx: BIT1};
    localparam pin_loc_t CC2_LOC1 = '{port: PORT_B, bit_idx: BIT3};
    localparam pin_loc_t CC3_LOC0 = '{port: PORT_C, bit_idx: BIT6};
    localparam pin_loc_t CC3_LOC1 = '{port: PORT_B, bit_idx: BIT5};
    localparam pin_loc_t TG_LOC0 = '{port: PORT_B, bit_idx: BIT5};
    localparam pin_loc_t TG_LOC1 = '{port: PORT_C, bit_idx: BIT4};

    // ======================================================
    // address decode
    logic [PORT_SEL_WIDTH-1:0] port_sel;
    logic [1:0] sub_sel;
    logic port_hit;
    logic steer_hit;

    assign port_sel = addr_i[PORT_LSB +: PORT_SEL_WIDTH];
    assign sub_sel = addr_i[SUB_LSB +: 2];
    assign port_hit = (addr_i[SUB_LSB-1:0] == '0)
        && (addr_i[ADDR_WIDTH-1:PORT_LSB] < PORTS);
    assign steer_hit = (addr_i == STEERING_ADDR);

    // ======================================================
    // steering register
    logic [7:0] steer_ff, nxt_steer;

    always_comb begin
        nxt_steer = steer_ff;
        // only this register; direction writes are decoded separately
        if (wr_i && steer_hit) begin
            nxt_steer = wdata_i & STEERING_MASK;
        end
    end

    // ======================================================
    // overrides
    pin_ovr_t [PORTS-1:0] ovr;
    pin_loc_t loc;

    always_comb begin
        ovr = '0;
        loc = '0;
        // later assignments win where candidates share a pad
        if (pwm_b_en_i) begin
            loc = steer_ff[SEL_PWM_B] ? PB_LOC1 : PB_LOC0;
            ovr[loc.port].en[loc.bit_idx] = 1'b1;
            ovr[loc.port].val[loc.bit_idx] = pwm_b_output_i;
        end
        if (capcmp3_en_i) begin
            loc = steer_ff[SEL_CAPCMP3] ? CC3_LOC1 : CC3_LOC0;
            ovr[loc.port].en[loc.bit_idx] = 1'b1;
            ovr[loc.port].val[loc.bit_idx] = capcmp3_out_i;
        end
        if (capcmp2_en_i) begin
            loc = steer_ff[SEL_CAPCMP2] ? CC2_LOC1 : CC2_LOC0;
            ovr[loc.port].en[loc.bit_idx] = 1'b1;
            ovr[loc.port].val[loc.bit_idx] = capcmp2_out_i;
        end
        if (comparator2_en_i) begin
            loc = steer_ff[SEL_COMPARATOR2] ? C2_LOC1 : C2_LOC0;
            ovr[loc.port].en[loc.bit_idx] = 1'b1;
            ovr[loc.port].val[loc.bit_idx] = comparator2_out_i;
        end
        if (latch_inv_en_i) begin
            loc = steer_ff[SEL_LATCH_INV] ? LI_LOC1 : LI_LOC0;
            ovr[loc.port].en[loc.bit_idx] = 1'b1;
            ovr[loc.port].val[loc.bit_idx] = latch_inverted_output_i;
        end
    end

    // ======================================================
    // ports
    logic [PORTS-1:0][WIDTH-1:0] direction;
    logic [PORTS-1:0][WIDTH-1:0] latch;
    logic [PORTS-1:0][WIDTH-1:0] analog;
    logic [PORTS-1:0][WIDTH-1:0] level;

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        logic sel;
        assign sel = wr_i && port_hit && (port_sel == PORT_SEL_WIDTH'(p));
        port_slice #(
            .WIDTH(WIDTH),
            .HAS_ANALOG(ANALOG_MAP[p])
        ) u_slice (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_direction_i(sel && (sub_sel == SUB_DIRECTION)),
            // both addresses land in the latch
            .wr_latch_i(sel && ((sub_sel == SUB_OUT_LATCH)
                || (sub_sel == SUB_PIN_LEVEL))),
            .wr_analog_i(sel && (sub_sel == SUB_ANALOG_SEL)),
            .wdata_i(wdata_i),
            .ovr_i(ovr[p]),
            .pin_i(pin_i[p]),
            .direction_o(direction[p]),
            .latch_o(latch[p]),
            .analog_o(analog[p]),
            .level_o(level[p]),
            .pin_o(pin_o[p]),
            .pin_oe_o(pin_oe_o[p])
        );
    end

    // ======================================================
    // peripheral inputs, from synchronised pin levels
    logic ss_ff, nxt_ss;
    logic tg_ff, nxt_tg;
    pin_loc_t ss_loc;
    pin_loc_t tg_loc;

    always_comb begin
        ss_loc = steer_ff[SEL_SLAVE_SELECT] ? SS_LOC1 : SS_LOC0;
        tg_loc = steer_ff[SEL_TIMER_GATE] ? TG_LOC1 : TG_LOC0;
        nxt_ss = level[ss_loc.port][ss_loc.bit_idx];
        nxt_tg = level[tg_loc.port][tg_loc.bit_idx];
    end

    // ======================================================
    // read back
    logic [WIDTH-1:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = '0;
        if (rd_i) begin
            if (steer_hit) begin
                nxt_rdata = steer_ff & STEERING_MASK;
            end else if (port_hit) begin
                unique case (sub_sel)
                    SUB_DIRECTION: nxt_rdata = direction[port_sel];
                    SUB_PIN_LEVEL: nxt_rdata = level[port_sel];
                    SUB_OUT_LATCH: nxt_rdata = latch[port_sel];
                    SUB_ANALOG_SEL: nxt_rdata = analog[port_sel];
                endcase
            end
        end
    end

    // ======================================================
    // state registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            steer_ff <= STEERING_RESET;
            ss_ff <= 1'b0;
            tg_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            steer_ff <= nxt_steer;
            ss_ff <= nxt_ss;
            tg_ff <= nxt_tg;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;
    assign slave_select_o = ss_ff;
    assign timer_gate_input_o = tg_ff;
    assign pin_function_steering_o = steer_ff;

endmodule

//--- sim/pin_steer_checker.sv
`timescale 1ns/100ps

module pin_steer_checker
    import pin_steer_pkg::*;
#(
    parameter int PORTS = NUM_PORTS,
    parameter int WIDTH = PORT_WIDTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [ADDR_WIDTH-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [WIDTH-1:0] rdata_o,
    // pins and peripherals
    input wire logic [PORTS-1:0][WIDTH-1:0] pin_i,
    input wire logic [PORTS-1:0][WIDTH-1:0] pin_o,
    input wire logic [PORTS-1:0][WIDTH-1:0] pin_oe_o,
    input wire logic pwm_b_output_i,
    input wire logic pwm_b_en_i,
    input wire logic [7:0] pin_function_steering_o
);
    // ======================================================
    // port d has no overrides and no analog, so it is the clean probe
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_top_bit_zero: assert property (pin_function_steering_o[7] == 1'b0)
        else $error("steering top bit set");
    a_steer_write: assert property (wr_i && addr_i == STEERING_ADDR |=>
        pin_function_steering_o == ($past(wdata_i) & STEERING_MASK))
        else $error("steering write lost");
    a_steer_read: assert property (rd_i && addr_i == STEERING_ADDR |=>
        rdata_o == pin_function_steering_o) else $error("steering read wrong");
    a_dir_drive: assert property (wr_i && addr_i == 8'h30 |=> ##1
        pin_oe_o[3] == ~$past(wdata_i, 2)) else $error("direction not on enable");
    a_latch_pin: assert property (wr_i && (addr_i == 8'h38 || addr_i == 8'h34) |=> ##1
        (pin_o[3] & pin_oe_o[3]) == ($past(wdata_i, 2) & pin_oe_o[3]))
        else $error("latch not on pin");
    a_latch_read: assert property (wr_i && addr_i == 8'h38 ##1 rd_i && addr_i == 8'h38 |=>
        rdata_o == $past(wdata_i, 2)) else $error("latch readback wrong");
    a_level_read: assert property (rd_i && addr_i == 8'h34 |=>
        rdata_o == $past(pin_i[3], 3)) else $error("pin level read wrong");
    a_pwm_takes: assert property (pwm_b_en_i && !pin_function_steering_o[SEL_PWM_B] |=>
        pin_oe_o[2][0] && pin_o[2][0] == $past(pwm_b_output_i))
        else $error("pwm b not on default pin");
    a_steer_dir: assert property (wr_i && addr_i == STEERING_ADDR |=> ##1
        $stable(pin_oe_o[3])) else $error("steering disturbed direction");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data outside read cycle");
    a_steer_reset: assert property ($fell(rst_i) |-> pin_function_steering_o == 8'h00)
        else $error("steering not cleared by reset");

    c_steer_write: cover property (wr_i && addr_i == STEERING_ADDR);
    c_pwm_moved: cover property (pwm_b_en_i && pin_function_steering_o[SEL_PWM_B]);
    c_level_read: cover property (rd_i && addr_i == 8'h34);
    c_latch_read: cover property (wr_i && addr_i == 8'h38 ##1 rd_i && addr_i == 8'h38);
endmodule

//--- sim/pad_model.sv
`timescale 1ns/100ps

module pad_model
    import pin_steer_pkg::*;
(
    // device side
    input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_o,
    input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_oe_o,
    // board side
    input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] ext_i,
    output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pin_i
);
    // ======================================================
    // a driven pad shows the device level, else the board drive
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps

module tb
    import pin_steer_pkg::*;
;
    typedef struct packed {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
    logic ss, tg;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [4:0] per_out = 5'h00, per_en = 5'h00;
    logic [4:0][7:0] pin_i, pin_o, pin_oe_o, ext = '0;
    logic [5:0] sp, op;
    int num_errors = 0, num_checks = 0;
    int fbit[5] = '{SEL_PWM_B, SEL_CAPCMP2, SEL_CAPCMP3, SEL_COMPARATOR2, SEL_LATCH_INV};
    logic [5:0] pa[5] = '{6'h10, 6'h11, 6'h16, 6'h05, 6'h05};
    logic [5:0] pb[5] = '{6'h0D, 6'h0B, 6'h0D, 6'h00, 6'h00};
    row_t rows[11] = '{'{8'h00, 8'hA5, 8'h00, 8'hA5}, '{8'h10, 8'h5A, 8'h10, 8'h5A},
        '{8'h20, 8'h0F, 8'h20, 8'h0F}, '{8'h30, 8'h00, 8'h30, 8'h00},
        '{8'h40, 8'h3C, 8'h40, 8'h3C}, '{8'h34, 8'hC3, 8'h38, 8'hC3},
        '{8'h48, 8'h81, 8'h48, 8'h81}, '{8'h50, 8'hFF, 8'h50, 8'h7F},
        '{8'h60, 8'hFF, 8'h60, 8'h00}, '{8'h2C, 8'hFF, 8'h2C, 8'h00},
        '{8'h50, 8'h00, 8'h50, 8'h00}};

    always #2 clk_i = ~clk_i;

    port_pin_steering i_port_pin_steering (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pin_i, .pin_o, .pin_oe_o, .pwm_b_output_i(per_out[0]), .pwm_b_en_i(per_en[0]),
        .capcmp2_out_i(per_out[1]), .capcmp2_en_i(per_en[1]), .capcmp3_out_i(per_out[2]),
        .capcmp3_en_i(per_en[2]), .comparator2_out_i(per_out[3]), .comparator2_en_i(per_en[3]),
        .latch_inverted_output_i(per_out[4]), .latch_inv_en_i(per_en[4]),
        .slave_select_o(ss), .timer_gate_input_o(tg), .pin_function_steering_o());
    pad_model i_pad_model (.pin_o, .pin_oe_o, .ext_i(ext), .pin_i);

    // ======================================================
    // bus cycles and compares
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    // write then read with no gap, as the bus allows
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 r = rdata_o;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ======================================================
    // nothing waits on a handshake, so one watchdog bounds the run
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, d);
            chk(d, rows[i].ex);
        end
        wt(2);
        chk(pin_o[3], 8'hC3);
        chk(pin_oe_o[3], 8'hFF);
        wr(8'h30, 8'hFF);
        ext[3] <= 8'h5A;
        wt(3);
        rd(8'h34, d);
        chk(d, 8'h5A);
        rd(8'h38, d);
        chk(d, 8'hC3);
        chk(pin_oe_o[3], 8'h00);
        wr_rd(8'h38, 8'h96, d);
        chk(d, 8'h96);
        for (int p = 0; p < 5; p++) wr(8'(p * 16), 8'hFF);
        ext[1] <= 8'hFF;
        wt(3);
        rd(8'h14, d);
        chk(d, 8'h00);
        wr(8'h1C, 8'h00);
        wt(3);
        rd(8'h14, d);
        chk(d, 8'hFF);
        // analog pin still drives its latch out
        wr(8'h08, 8'hAA);
        wr(8'h00, 8'h00);
        wt(2);
        chk(pin_o[0], 8'hAA);
        chk(pin_oe_o[0], 8'hFF);
        wr(8'h00, 8'hFF);
        ext[0] <= 8'h20;
        wt(4);
        chk({7'h00, tg}, 8'h01);
        chk({7'h00, ss}, 8'h00);
        wr(8'h0C, 8'h00);
        wt(4);
        chk({7'h00, ss}, 8'h01);
        wr(8'h50, 8'h02);
        wt(4);
        chk({7'h00, ss}, 8'h00);
        wr(8'h50, 8'h20);
        wt(4);
        chk({7'h00, tg}, 8'h00);
        @(posedge clk_i);
        ext[2] <= 8'h10;
        wt(4);
        chk({7'h00, tg}, 8'h01);
        rd(8'h50, d);
        chk(d, 8'h20);
        rd(8'h20, d);
        chk(d, 8'hFF);
        @(posedge clk_i);
        per_out <= 5'h1F;
        for (int i = 0; i < 5; i++) begin
            for (int s = 0; s < 2; s++) begin
                @(posedge clk_i);
                per_en <= 5'(1 << i);
                wr(8'h50, 8'(s << fbit[i]));
                wt(2);
                sp = s ? pb[i] : pa[i];
                op = s ? pa[i] : pb[i];
                chk({7'h00, pin_oe_o[sp[5:3]][sp[2:0]]}, 8'h01);
                chk({7'h00, pin_o[sp[5:3]][sp[2:0]]}, 8'h01);
                chk({7'h00, pin_oe_o[op[5:3]][op[2:0]]}, 8'h00);
            end
        end
        // two peripherals on one pad: the higher priority one wins
        @(posedge clk_i);
        per_out <= 5'h10;
        per_en <= 5'h18;
        wr(8'h50, 8'h00);
        wt(2);
        chk({7'h00, pin_o[0][5]}, 8'h01);
        @(posedge clk_i);
        per_en <= 5'h00;
        // second reset in mid-run
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h50, d);
        chk(d, 8'h00);
        chk(pin_oe_o[2], 8'h00);
        give_verdict();
    end
endmodule

bind port_pin_steering pin_steer_checker #(.PORTS(PORTS), .WIDTH(WIDTH)) i_chk (.clk_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o, .pwm_b_output_i,
    .pwm_b_en_i, .pin_function_steering_o);
